/* File: hw/fps_pkg.sv */
// Shared constants and types for the flash program status and bypass sequencer.
// Assumes a 16-bit MCU write/read bus and an external flash array with a
// combinational read port.
package fps_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int SEL_W = 20;
	localparam int CNT_W = 16;
	// Instruction bytes and unlock addresses; only the low 12 address bits decode.
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [11:0] ADDR_UNLOCK1 = 12'hAAA;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'h554;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_BULK = 8'h10;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	// Status bit positions in the low byte of a read word.
	localparam int POS_POLL = 7;
	localparam int POS_TOGGLE = 6;
	localparam int POS_ERROR = 5;
	localparam int POS_WINDOW = 3;
	// Timing figures and their cycle counts at the 50 MHz reference clock.
	localparam int CLK_MHZ = 50;
	localparam int PROT_HOLD_US = 100;
	localparam int WINDOW_US = 100;
	localparam int WINDOW_PCT = 20;
	localparam int GAP_US = 80;
	localparam int PROG_TMO_US = 200;
	localparam int PROT_HOLD_CYC = PROT_HOLD_US * CLK_MHZ;
	localparam int WINDOW_CYC = (WINDOW_US * CLK_MHZ * (100 + WINDOW_PCT)) / 100;
	localparam int GAP_CYC = GAP_US * CLK_MHZ;
	localparam int PROG_TMO_CYC = PROG_TMO_US * CLK_MHZ;
	// One bus write as seen after synchronisation.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [SEL_W-1:0] sel;
	} fps_bus_type;
	typedef enum logic [3:0] {
		S_IDLE, S_UNLOCK1, S_UNLOCK2, S_PROG_WAIT, S_E_UNLOCK0, S_E_UNLOCK1,
		S_E_CMD, S_E_WINDOW, S_PROG_CHECK, S_PROGRAMMING, S_ERASING,
		S_PROT_HOLD, S_ERROR, S_BYPASS, S_BYP_PROG, S_BYP_EXIT
	} fps_state_type;
endpackage : fps_pkg

/* File: hw/fps_sequencer.sv */
// Flash instruction decoder with program/erase status reporting and bypass mode.
// Assumes bus pins are asynchronous to ref_clk and held stable around strobes,
// and that the array answers array_rdata combinationally from array_addr.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Busy reads return complemented programmed bit.
// RULE_02: Polling valid after fourth/sixth write pulse.
// RULE_03: Erase polls zero, erased data reads one.
// RULE_04: Program to protected sector is ignored.
// RULE_05: All-protected erase: poll low about 100us.
// RULE_06: Toggle bit flips per read while busy.
// RULE_07: After completion toggling stops, data returns.
// RULE_08: Toggle valid after fourth/sixth write pulse.
// RULE_09: All-protected erase: toggle zero about 100us.
// RULE_10: Error bit zero normally, one on failure.
// RULE_11: Error on zero-to-one program or timeout.
// RULE_12: Error cleared only by reset instruction.
// RULE_13: Erase window bit low, then one.
// RULE_14: Host checks completion after each operation.
// RULE_15: Host polling completion and error recheck.
// RULE_16: Host reads erasing sector for status.
// RULE_17: Host toggle checking completion and recheck.
// RULE_18: Host may reread programmed word afterwards.
// RULE_19: Two unlocks then 20h enters bypass.
// RULE_20: Bypass programs with A0h then data.
// RULE_21: Bypass accepts only bypass program, exit.
// RULE_22: Bypass exit is 90h then 00h.
// RULE_23: Unlocks are AAh@AAAh, 55h@554h, selected.
// RULE_24: Invalid sequence or gap returns read mode.
// RULE_25: Protection vector checked before any operation.
module fps_sequencer #(
	parameter int PROT_HOLD_CYC = fps_pkg::PROT_HOLD_CYC,
	parameter int WINDOW_CYC = fps_pkg::WINDOW_CYC,
	parameter int GAP_CYC = fps_pkg::GAP_CYC,
	parameter int PROG_TMO_CYC = fps_pkg::PROG_TMO_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// MCU bus pins
	input wire logic [fps_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [fps_pkg::DATA_W-1:0] bus_wdata,
	input wire logic bus_wr_n,
	input wire logic bus_rd_n,
	input wire logic [15:0] primary_sector_selects,
	input wire logic [3:0] secondary_sector_selects,
	output logic [fps_pkg::DATA_W-1:0] bus_rdata,
	output logic bus_rvalid,
	output logic ready_busy_pin,
	// Sector protection, one bit per sector
	input wire logic [fps_pkg::SEL_W-1:0] sector_protect,
	// Flash array side
	output logic [fps_pkg::ADDR_W-1:0] array_addr,
	output logic [fps_pkg::DATA_W-1:0] array_wdata,
	output logic [fps_pkg::SEL_W-1:0] array_sel,
	output logic array_prog,
	output logic array_erase,
	input wire logic [fps_pkg::DATA_W-1:0] array_rdata,
	input wire logic array_done,
	input wire logic array_fail
);
	fps_pkg::fps_bus_type pin_s1;
	fps_pkg::fps_bus_type pin_s2;
	logic [1:0] wr_s1;
	logic [1:0] wr_s2;
	logic wr_q;
	logic rd_q;
	logic wr_evt;
	logic rd_evt;
	fps_pkg::fps_state_type state;
	logic [fps_pkg::CNT_W-1:0] cnt;
	logic in_bypass;
	logic erase_is_erase;
	logic [fps_pkg::DATA_W-1:0] prog_data;
	logic toggle;
	logic window_bit;
	logic rd_pend;
	logic rd_stat;
	logic [7:0] wbyte;
	logic [11:0] waddr;
	logic wsel_any;
	logic prog_conflict;
	logic busy;
	logic cmd_state;
	fps_pkg::fps_state_type rest_state;

	// Two-stage synchronisers for all bus pins; edges are taken from stage two.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			wr_s1 <= 2'h3;
			wr_s2 <= 2'h3;
			wr_q <= 1'b1;
			rd_q <= 1'b1;
		end else begin
			pin_s1 <= '{addr: bus_addr, data: bus_wdata,
				sel: {secondary_sector_selects, primary_sector_selects}};
			pin_s2 <= pin_s1;
			wr_s1 <= {bus_rd_n, bus_wr_n};
			wr_s2 <= wr_s1;
			wr_q <= wr_s2[0];
			rd_q <= wr_s2[1];
		end
	end

	// A write is taken on the rising strobe edge, a read on the falling one.
	assign wr_evt = wr_s2[0] && !wr_q;
	assign rd_evt = !wr_s2[1] && rd_q;
	assign wbyte = pin_s2.data[7:0];
	assign waddr = pin_s2.addr[11:0];
	assign wsel_any = |pin_s2.sel;
	assign prog_conflict = |(~array_rdata & prog_data);
	assign rest_state = in_bypass ? fps_pkg::S_BYPASS : fps_pkg::S_IDLE;
	assign busy = (state == fps_pkg::S_PROG_CHECK) || (state == fps_pkg::S_PROGRAMMING) ||
		(state == fps_pkg::S_ERASING) || (state == fps_pkg::S_E_WINDOW) ||
		(state == fps_pkg::S_PROT_HOLD) || (state == fps_pkg::S_ERROR);
	assign cmd_state = (state == fps_pkg::S_UNLOCK1) || (state == fps_pkg::S_UNLOCK2) ||
		(state == fps_pkg::S_PROG_WAIT) || (state == fps_pkg::S_E_UNLOCK0) ||
		(state == fps_pkg::S_E_UNLOCK1) || (state == fps_pkg::S_E_CMD) ||
		(state == fps_pkg::S_BYP_PROG) || (state == fps_pkg::S_BYP_EXIT);

	// Instruction decoder and embedded-operation sequencer; cnt times each state.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= fps_pkg::S_IDLE;
			cnt <= '0;
			in_bypass <= 1'b0;
			erase_is_erase <= 1'b0;
			prog_data <= '0;
			window_bit <= 1'b0;
			array_wdata <= '0;
			array_sel <= '0;
			array_prog <= 1'b0;
			array_erase <= 1'b0;
		end else begin
			array_prog <= 1'b0;
			array_erase <= 1'b0;
			cnt <= (wr_evt || cnt == '1) ? '0 : cnt + 1'b1;
			case (state)
			fps_pkg::S_IDLE: begin
				// RULE_23: first unlock byte
				if (wr_evt && wsel_any && wbyte == fps_pkg::CMD_UNLOCK1 &&
					waddr == fps_pkg::ADDR_UNLOCK1) begin
					state <= fps_pkg::S_UNLOCK1;
				end
			end
			fps_pkg::S_UNLOCK1: begin
				// RULE_23: second unlock byte
				if (wr_evt) begin
					state <= (wsel_any && wbyte == fps_pkg::CMD_UNLOCK2 &&
						waddr == fps_pkg::ADDR_UNLOCK2) ? fps_pkg::S_UNLOCK2 : fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_UNLOCK2: begin
				// RULE_19: third byte selects program, erase or bypass entry
				if (wr_evt) begin
					case (wbyte)
					fps_pkg::CMD_PROGRAM: state <= fps_pkg::S_PROG_WAIT;
					fps_pkg::CMD_ERASE: state <= fps_pkg::S_E_UNLOCK0;
					fps_pkg::CMD_BYPASS: begin
						in_bypass <= 1'b1;
						state <= fps_pkg::S_BYPASS;
					end
					default: state <= fps_pkg::S_IDLE;
					endcase
				end
			end
			fps_pkg::S_PROG_WAIT, fps_pkg::S_BYP_PROG: begin
				// RULE_04: protected or unselected target is dropped silently
				// RULE_25: protection checked before programming
				if (wr_evt) begin
					if (!wsel_any || |(pin_s2.sel & sector_protect)) begin
						state <= rest_state;
					end else begin
						prog_data <= pin_s2.data;
						array_wdata <= pin_s2.data;
						array_sel <= pin_s2.sel;
						erase_is_erase <= 1'b0;
						state <= fps_pkg::S_PROG_CHECK;
					end
				end
			end
			fps_pkg::S_PROG_CHECK: begin
				// RULE_11: a zero cannot be programmed back to one
				if (prog_conflict) begin
					state <= fps_pkg::S_ERROR;
				end else begin
					array_prog <= 1'b1;
					state <= fps_pkg::S_PROGRAMMING;
				end
			end
			fps_pkg::S_PROGRAMMING: begin
				// RULE_11: internal time-out or array failure flags an error
				if (array_fail || cnt >= fps_pkg::CNT_W'(PROG_TMO_CYC - 1)) begin
					state <= fps_pkg::S_ERROR;
				end else if (array_done) begin
					state <= rest_state;
				end
			end
			fps_pkg::S_E_UNLOCK0: begin
				if (wr_evt) begin
					state <= (wsel_any && wbyte == fps_pkg::CMD_UNLOCK1 &&
						waddr == fps_pkg::ADDR_UNLOCK1) ? fps_pkg::S_E_UNLOCK1 : fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_E_UNLOCK1: begin
				if (wr_evt) begin
					state <= (wsel_any && wbyte == fps_pkg::CMD_UNLOCK2 &&
						waddr == fps_pkg::ADDR_UNLOCK2) ? fps_pkg::S_E_CMD : fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_E_CMD: begin
				// RULE_25: only unprotected sectors join the erase set
				erase_is_erase <= 1'b1;
				if (wr_evt && wbyte == fps_pkg::CMD_SECTOR && wsel_any) begin
					array_sel <= pin_s2.sel & ~sector_protect;
					window_bit <= 1'b0;
					state <= fps_pkg::S_E_WINDOW;
				end else if (wr_evt && wbyte == fps_pkg::CMD_BULK &&
					waddr == fps_pkg::ADDR_UNLOCK1) begin
					array_sel <= ~sector_protect;
					if (&sector_protect) begin
						state <= fps_pkg::S_PROT_HOLD;
					end else begin
						array_erase <= 1'b1;
						state <= fps_pkg::S_ERASING;
					end
				end else if (wr_evt) begin
					state <= fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_E_WINDOW: begin
				// RULE_13: more sector commands extend the window and raise the bit
				if (wr_evt && wbyte == fps_pkg::CMD_SECTOR && wsel_any) begin
					array_sel <= array_sel | (pin_s2.sel & ~sector_protect);
					window_bit <= 1'b1;
				end else if (wr_evt) begin
					state <= fps_pkg::S_IDLE;
				end else if (cnt >= fps_pkg::CNT_W'(WINDOW_CYC - 1)) begin
					window_bit <= 1'b1;
					// RULE_05: nothing to erase means a timed protected hold
					if (array_sel == '0) begin
						// The hold is timed from its own start, not from the window's count.
						cnt <= '0;
						state <= fps_pkg::S_PROT_HOLD;
					end else begin
						array_erase <= 1'b1;
						state <= fps_pkg::S_ERASING;
					end
				end
			end
			fps_pkg::S_ERASING: begin
				// RULE_10: erase failure sets the error state
				if (array_fail) begin
					state <= fps_pkg::S_ERROR;
				end else if (array_done) begin
					state <= fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_PROT_HOLD: begin
				// RULE_09: hold ends after the protected-erase interval
				if (cnt >= fps_pkg::CNT_W'(PROT_HOLD_CYC - 1)) begin
					state <= fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_ERROR: begin
				// RULE_12: only the reset instruction leaves the error state
				if (wr_evt && wbyte == fps_pkg::CMD_RESET) begin
					in_bypass <= 1'b0;
					state <= fps_pkg::S_IDLE;
				end
			end
			fps_pkg::S_BYPASS: begin
				// RULE_21: other bytes are ignored while bypass is active
				// RULE_20: A0h arms a single-write program
				if (wr_evt && wbyte == fps_pkg::CMD_PROGRAM) begin
					state <= fps_pkg::S_BYP_PROG;
				end else if (wr_evt && wbyte == fps_pkg::CMD_BYP_EXIT1) begin
					state <= fps_pkg::S_BYP_EXIT;
				end
			end
			fps_pkg::S_BYP_EXIT: begin
				// RULE_22: 00h completes the exit, anything else stays in bypass
				if (wr_evt) begin
					in_bypass <= (wbyte != fps_pkg::CMD_BYP_EXIT2);
					state <= (wbyte == fps_pkg::CMD_BYP_EXIT2) ? fps_pkg::S_IDLE : fps_pkg::S_BYPASS;
				end
			end
			default: state <= fps_pkg::S_IDLE;
			endcase
			// RULE_24: an overlong gap between instruction bytes aborts the sequence
			if (cmd_state && !wr_evt && cnt >= fps_pkg::CNT_W'(GAP_CYC - 1)) begin
				state <= rest_state;
			end
		end
	end

	// Toggle flips on each read while busy with a sector selected, except in the protected hold; it rests
	// once the operation completes without error, so two equal reads mean completion.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle <= 1'b0;
		end else if (rd_evt && busy && wsel_any && state != fps_pkg::S_PROT_HOLD) begin
			// RULE_06: flip on each status read
			toggle <= !toggle;
		end
	end

	// Read path: the address is presented one cycle, the word is returned the next.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_addr <= '0;
			rd_pend <= 1'b0;
			rd_stat <= 1'b0;
			bus_rdata <= '0;
			bus_rvalid <= 1'b0;
		end else begin
			rd_pend <= rd_evt;
			bus_rvalid <= rd_pend;
			if (rd_evt) begin
				array_addr <= pin_s2.addr;
				// RULE_02: status appears only once the final write was taken
				rd_stat <= busy;
			end else if (wr_evt && (state == fps_pkg::S_PROG_WAIT ||
				state == fps_pkg::S_BYP_PROG)) begin
				array_addr <= pin_s2.addr;
			end
			if (rd_pend && rd_stat) begin
				bus_rdata <= array_rdata;
				// RULE_01: complement of the bit being programmed
				// RULE_03: erase and protected hold report zero
				bus_rdata[fps_pkg::POS_POLL] <= !erase_is_erase && !prog_data[fps_pkg::POS_POLL];
				// RULE_08: toggle reported only in busy states
				bus_rdata[fps_pkg::POS_TOGGLE] <= (state == fps_pkg::S_PROT_HOLD) ? 1'b0 : toggle;
				// RULE_10: error bit reflects the error state
				bus_rdata[fps_pkg::POS_ERROR] <= (state == fps_pkg::S_ERROR);
				bus_rdata[fps_pkg::POS_WINDOW] <= window_bit;
			end else if (rd_pend) begin
				// RULE_07: plain array data once idle
				bus_rdata <= array_rdata;
			end
		end
	end

	// Ready/busy pin is high when no embedded operation runs.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_busy_pin <= 1'b1;
		end else begin
			ready_busy_pin <= !busy || (state == fps_pkg::S_ERROR);
		end
	end

	a_prog_protect: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
		wr_evt && state == fps_pkg::S_PROG_WAIT && |(pin_s2.sel & sector_protect)
		|=> state == fps_pkg::S_IDLE ##1 !array_prog)
		else $error("program into protected sector was not dropped");
	a_zero_to_one: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_11
		state == fps_pkg::S_PROG_CHECK && prog_conflict |=> state == fps_pkg::S_ERROR && !array_prog)
		else $error("zero-to-one program did not raise error");
	a_error_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
		state == fps_pkg::S_ERROR && !(wr_evt && wbyte == fps_pkg::CMD_RESET)
		|=> state == fps_pkg::S_ERROR)
		else $error("error state left without reset instruction");
	a_prot_hold_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
		$rose(state == fps_pkg::S_PROT_HOLD) |-> (state == fps_pkg::S_PROT_HOLD)[*8])
		else $error("protected erase hold ended too early");
	a_toggle_stops: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
		!busy && $past(!busy) |-> $stable(toggle))
		else $error("toggle changed while idle");
	a_poll_erase: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
		rd_pend && rd_stat && erase_is_erase |=> bus_rvalid && !bus_rdata[fps_pkg::POS_POLL])
		else $error("poll bit not zero during erase");
	a_gap_abort: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_24
		cmd_state && !wr_evt && cnt == fps_pkg::CNT_W'(GAP_CYC - 1)
		|=> state == fps_pkg::S_IDLE || state == fps_pkg::S_BYPASS)
		else $error("byte gap did not abort instruction");
	a_bypass_exit: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_22
		state == fps_pkg::S_BYP_EXIT && wr_evt && wbyte == fps_pkg::CMD_BYP_EXIT2
		|=> state == fps_pkg::S_IDLE && !in_bypass)
		else $error("bypass exit did not return to read mode");
	a_bypass_enter: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_19
		state == fps_pkg::S_UNLOCK2 && wr_evt && wbyte == fps_pkg::CMD_BYPASS
		|=> state == fps_pkg::S_BYPASS && in_bypass)
		else $error("bypass entry not taken");
endmodule : fps_sequencer
`default_nettype wire

/* File: tb/fps_array_model.sv */
// Behavioural flash array standing behind the sequencer's array port.
// Assumes one-cycle start pulses and a combinational read of array_addr.
`timescale 1ns/1ps
`default_nettype none
module fps_array_model #(
	parameter int BUSY_CYC = 35
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Array port
	input wire logic [15:0] array_addr,
	input wire logic [15:0] array_wdata,
	input wire logic array_prog,
	input wire logic array_erase,
	output logic [15:0] array_rdata,
	output logic array_done,
	output logic array_fail,
	// Scenario control
	input wire logic fail_en
);
	logic [15:0] mem [0:255];
	logic [15:0] pa;
	logic [15:0] pd;
	logic pe;
	int cnt;
	// The array starts erased, so every word reads as ones.
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
	end
	// Reads answer at once from the presented address.
	assign array_rdata = mem[array_addr[7:0]];
	// completion or failure
	// Programming only clears bits, like a real cell; a forced failure leaves data untouched.
	always @(posedge ref_clk or negedge rst_n) begin
		array_done <= 1'b0;
		array_fail <= 1'b0;
		if (!rst_n) begin
			cnt <= 0;
		end else if (array_prog || array_erase) begin
			cnt <= BUSY_CYC;
			pa <= array_addr;
			pd <= array_wdata;
			pe <= array_erase;
		end else if (cnt == 1) begin
			cnt <= 0;
			array_fail <= fail_en;
			array_done <= !fail_en;
			if (!fail_en && pe) for (int i = 0; i < 256; i++) mem[i] <= 16'hFFFF;
			if (!fail_en && !pe) mem[pa[7:0]] <= mem[pa[7:0]] & pd;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : fps_array_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the flash status and bypass sequencer.
// Assumes the array model finishes each operation after a fixed delay.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] val;
		logic flip;
	} fps_exp_type;
	logic ref_clk, rst_n, bus_wr_n, bus_rd_n, bus_rvalid, ready_busy_pin, fail_en;
	logic [15:0] bus_addr, bus_wdata, bus_rdata, array_addr, array_wdata, array_rdata;
	logic [15:0] primary_sector_selects;
	logic [3:0] secondary_sector_selects;
	logic [19:0] sector_protect, array_sel;
	logic array_prog, array_erase, array_done, array_fail, last6;
	fps_exp_type exp_q[$];
	fps_exp_type e;
	int num_errors, samples_checked, cyc;
	int seed = 32'h8f98b2e6;
	logic [15:0] d1, d2;
	// Short counts keep the run brief; the program limit sits above the array delay.
	fps_sequencer #(.PROT_HOLD_CYC(20), .WINDOW_CYC(30), .GAP_CYC(40), .PROG_TMO_CYC(200))
	i_dut (.ref_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr_n, .bus_rd_n,
		.primary_sector_selects, .secondary_sector_selects, .bus_rdata, .bus_rvalid,
		.ready_busy_pin, .sector_protect, .array_addr, .array_wdata, .array_sel,
		.array_prog, .array_erase, .array_rdata, .array_done, .array_fail);
	fps_array_model i_array (.ref_clk, .rst_n, .array_addr, .array_wdata, .array_prog,
		.array_erase, .array_rdata, .array_done, .array_fail, .fail_en);
	// Free-running reference clock.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic results;
		if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic cmp_word(input logic [15:0] got, input fps_exp_type x);
		samples_checked++;
		if ((got & x.mask) !== (x.val & x.mask) || (x.flip && got[6] === last6)) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, x.val);
		end
	endtask : cmp_word
	task automatic cmp_pin(input logic got, input logic want);
		samples_checked++;
		if (got !== want) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : cmp_pin
	// Each answered read takes the oldest expectation; an unexpected answer counts as wrong.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
		if (bus_rvalid === 1'b1) begin
			if (exp_q.size() == 0) e = '{16'hFFFF, ~bus_rdata, 1'b0};
			else e = exp_q.pop_front();
			cmp_word(bus_rdata, e);
			last6 = bus_rdata[6];
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		bus_wr_n = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] v,
		input logic f);
		@(negedge ref_clk);
		bus_addr = a;
		bus_rd_n = 1'b0;
		exp_q.push_back('{m, v, f});
		repeat (4) @(negedge ref_clk);
		bus_rd_n = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask : rd
	task automatic ul;
		wr(16'h0AAA, 16'h00AA);
		wr(16'h0554, 16'h0055);
	endtask : ul
	task automatic prog(input logic [15:0] a, input logic [15:0] d);
		ul();
		wr(16'h0AAA, 16'h00A0);
		wr(a, d);
	endtask : prog
	task automatic wait_rdy;
		int n;
		n = 0;
		while (ready_busy_pin !== 1'b1 && n < 500) begin
			@(negedge ref_clk);
			n++;
		end
		cmp_pin(ready_busy_pin, 1'b1);
		repeat (4) @(negedge ref_clk);
	endtask : wait_rdy
	// Main sequence; inputs change on the falling edge only.
	initial begin
		{bus_addr, bus_wdata, d1, d2} = '0;
		{bus_wr_n, bus_rd_n, rst_n, fail_en} = 4'hC;
		primary_sector_selects = 16'h0001;
		secondary_sector_selects = 4'h0;
		sector_protect = 20'h00000;
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		rd(16'h0010, 16'hFFFF, 16'hFFFF, 1'b0);
		wr(16'h0AAA, 16'h00AA);
		repeat (60) @(negedge ref_clk);
		wr(16'h0554, 16'h0055);
		wr(16'h0AAA, 16'h00A0);
		wr(16'h0010, 16'h1234);
		ul();
		wr(16'h0AAA, 16'h0077);
		wr(16'h0AAA, 16'h00A0);
		wr(16'h0010, 16'h1234);
		rd(16'h0010, 16'hFFFF, 16'hFFFF, 1'b0);
		prog(16'h0010, 16'h1234);
		rd(16'h0010, 16'h00A0, 16'h0080, 1'b0);
		rd(16'h0010, 16'h00E0, 16'h0080, 1'b1);
		cmp_pin(ready_busy_pin, 1'b0);
		wait_rdy();
		rd(16'h0010, 16'hFFFF, 16'h1234, 1'b0);
		rd(16'h0010, 16'hFFFF, 16'h1234, 1'b0);
		sector_protect = 20'h00001;
		prog(16'h0011, 16'h0000);
		repeat (10) @(negedge ref_clk);
		cmp_pin(ready_busy_pin, 1'b1);
		rd(16'h0011, 16'hFFFF, 16'hFFFF, 1'b0);
		sector_protect = 20'h00000;
		prog(16'h0010, 16'h00FF);
		rd(16'h0010, 16'h00A0, 16'h0020, 1'b0);
		wr(16'h0AAA, 16'h00AA);
		rd(16'h0010, 16'h0020, 16'h0020, 1'b0);
		wr(16'h0AAA, 16'h00F0);
		rd(16'h0010, 16'hFFFF, 16'h1234, 1'b0);
		fail_en = 1'b1;
		prog(16'h0012, 16'h0034);
		rd(16'h0012, 16'h00A0, 16'h0080, 1'b0);
		wait_rdy();
		rd(16'h0012, 16'h0020, 16'h0020, 1'b0);
		rd(16'h0012, 16'h00A0, 16'h00A0, 1'b0);
		fail_en = 1'b0;
		wr(16'h0AAA, 16'h00F0);
		rd(16'h0012, 16'hFFFF, 16'hFFFF, 1'b0);
		d1 = 16'($random(seed));
		d2 = 16'($random(seed));
		ul();
		wr(16'h0AAA, 16'h0020);
		wr(16'h0000, 16'h00A0);
		wr(16'h0020, d1);
		rd(16'h0020, 16'h0080, {8'h00, ~d1[7], 7'h00}, 1'b0);
		wait_rdy();
		wr(16'h0000, 16'h0080);
		wr(16'h0000, 16'h00A0);
		wr(16'h0021, d2);
		wait_rdy();
		wr(16'h0000, 16'h0090);
		wr(16'h0000, 16'h0000);
		rd(16'h0020, 16'hFFFF, d1, 1'b0);
		rd(16'h0021, 16'hFFFF, d2, 1'b0);
		wr(16'h0000, 16'h00A0);
		wr(16'h0022, 16'h0000);
		rd(16'h0022, 16'hFFFF, 16'hFFFF, 1'b0);
		for (int k = 0; k < 2; k++) begin
			sector_protect = k ? 20'hFFFFF : 20'h00000;
			ul();
			wr(16'h0AAA, 16'h0080);
			ul();
			wr(16'h0010, 16'h0030);
			if (k == 0) begin
				rd(16'h0010, 16'h0088, 16'h0000, 1'b0);
				repeat (30) @(negedge ref_clk);
				rd(16'h0010, 16'h0088, 16'h0008, 1'b0);
				wait_rdy();
			end else begin
				repeat (28) @(negedge ref_clk);
				rd(16'h0010, 16'h00C0, 16'h0000, 1'b0);
				repeat (30) @(negedge ref_clk);
			end
			rd(16'h0010, 16'hFFFF, 16'hFFFF, 1'b0);
			cmp_pin(array_sel === (k ? 20'h00000 : 20'h00001), 1'b1);
		end
		// Bulk erase must clear a freshly programmed word.
		sector_protect = 20'h00000;
		prog(16'h0030, 16'h0F0F);
		wait_rdy();
		rd(16'h0030, 16'hFFFF, 16'h0F0F, 1'b0);
		ul();
		wr(16'h0AAA, 16'h0080);
		ul();
		wr(16'h0AAA, 16'h0010);
		rd(16'h0030, 16'h00A0, 16'h0000, 1'b0);
		wait_rdy();
		rd(16'h0030, 16'hFFFF, 16'hFFFF, 1'b0);
		repeat (10) @(negedge ref_clk);
		if (exp_q.size() != 0) num_errors++;
		results();
	end
endmodule : tb_top
`default_nettype wire
